//--- design/flash_seq_pkg.sv
// constants for the host-side flash block write sequencer
// ==========================================================
// How it works
// - host reads the whole target block into its own buffer and patches it
// - host points the table address at the block and erases it first
// - after erase the table address is reloaded with the block start
// - host writes every byte to the latches; the device advances the address
// - region select is set to program flash before the write starts
// - erase-select cleared and write-enable set so a write, not erase, runs
// - interrupts held off around unlock and write, restored after it ends
// - write-start is set right after the unlock sequence unless software aborts in st_unlock2
// - table address lies inside the latched block when write-start is set
// - host reads the block back and compares it with the intended data
package flash_seq_pkg;
	// ======================================================
	// host register map
	localparam logic [3:0] reg_ctrl = 4'h0;
	localparam logic [3:0] reg_status = 4'h1;
	localparam logic [3:0] reg_base = 4'h2;
	localparam logic [3:0] reg_data = 4'h3;
	localparam logic [3:0] reg_index = 4'h4;
	localparam logic [3:0] reg_mismatch = 4'h5;
	localparam int ctrl_start_bit = 0;
	localparam int ctrl_abort_bit = 1;
	// ======================================================
	// device memory control register fields
	localparam int region_lsb = 6;
	localparam logic [1:0] region_program = 2'h1;
	localparam int erase_sel_bit = 4;
	localparam int write_en_bit = 2;
	localparam int write_start_bit = 1;
	localparam logic [7:0] unlock_first = 8'h55;
	localparam logic [7:0] unlock_second = 8'haa;
	// ======================================================
	// timing
	localparam int clk_mhz = 50;
	localparam int write_time_us = 2000;
	localparam int block_time_us = 6000;
	localparam int write_cycles = write_time_us * clk_mhz;
	localparam int block_cycles = block_time_us * clk_mhz;
	// ======================================================
	// sequencer states
	typedef enum logic [3:0] {
		st_idle = 4'b0000,
		st_read = 4'b0001,
		st_erase = 4'b0010,
		st_load = 4'b0011,
		st_fill = 4'b0100,
		st_setup = 4'b0101,
		st_unlock1 = 4'b0110,
		st_unlock2 = 4'b0111,
		st_go = 4'b1000,
		st_wait = 4'b1001,
		st_verify = 4'b1010,
		st_done = 4'b1011
	} seq_state_t;
endpackage : flash_seq_pkg

//--- design/flash_cycle_timer.sv
// watchdog timer bounding device busy phases
`timescale 1ns/10ps
`default_nettype none
module flash_cycle_timer
	import flash_seq_pkg::*;
#(
	parameter int limit = block_cycles
)
(
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic clear,
	input wire logic run,
	output logic expired
);
	localparam int cw = $clog2(limit + 1);
	logic [cw-1:0] count;
	initial
	begin
		if (limit < 1)
			$error("timer limit too small");
	end
	always_ff @(posedge ref_clk)
	begin
		if (rst || clear)
			count <= '0;
		else if (run && count != cw'(limit))
			count <= count + 1'b1;
	end
	always_ff @(posedge ref_clk)
	begin
		if (rst || clear)
			expired <= 1'b0;
		else
			expired <= (count == cw'(limit));
	end
endmodule : flash_cycle_timer
`default_nettype wire

//--- design/flash_block_ram.sv
// block image buffer held by the host
`timescale 1ns/10ps
`default_nettype none
module flash_block_ram #(
	parameter int depth = 64,
	parameter int aw = 6
)
(
	input wire logic ref_clk,
	input wire logic we,
	input wire logic [aw-1:0] waddr,
	input wire logic [7:0] wdata,
	input wire logic [aw-1:0] raddr,
	output logic [7:0] rdata
);
	logic [7:0] mem [depth];
	initial
	begin
		if (depth > (1 << aw))
			$error("depth exceeds address range");
	end
	always_ff @(posedge ref_clk)
	begin
		if (we)
			mem[waddr] <= wdata;
	end
	always_ff @(posedge ref_clk)
	begin
		rdata <= mem[raddr];
	end
endmodule : flash_block_ram
`default_nettype wire

//--- design/flash_block_write_sequencer.sv
// host sequencer driving one flash block read-modify-erase-write-verify
`timescale 1ns/10ps
`default_nettype none
module flash_block_write_sequencer
	import flash_seq_pkg::*;
#(
	parameter int block_bytes = 64,
	parameter int addr_width = 22,
	parameter int busy_limit = block_cycles
)
(
	input wire logic ref_clk,
	input wire logic rst,
	// software port
	input wire logic [3:0] sw_addr,
	input wire logic [31:0] sw_wdata,
	input wire logic sw_wr,
	input wire logic sw_rd,
	output logic [31:0] sw_rdata,
	// device table access
	output logic [addr_width-1:0] table_addr,
	output logic table_addr_load,
	output logic table_write,
	output logic [7:0] table_wdata,
	output logic table_read,
	input wire logic [7:0] table_rdata,
	input wire logic table_rvalid,
	// device control
	output logic [7:0] mem_control_one,
	output logic mem_control_write,
	output logic [7:0] unlock_data,
	output logic unlock_write,
	output logic erase_start,
	output logic irq_disable,
	input wire logic dev_busy,
	input wire logic write_start_status
);
	localparam int bw = $clog2(block_bytes);
	initial
	begin
		if (block_bytes < 2 || (block_bytes & (block_bytes - 1)) != 0)
			$error("block_bytes must be a power of two");
		if (addr_width <= bw)
			$error("addr_width too small");
	end
	// =====================================================
	// state
	seq_state_t state;
	seq_state_t next_state;
	logic [bw:0] index;
	logic [addr_width-1:0] base;
	logic [7:0] patch_data;
	logic [bw-1:0] patch_index;
	logic patch_pending;
	logic rd_wait;
	logic error_flag;
	logic timeout_flag;
	logic busy_seen;
	logic [bw:0] mismatch_count;
	logic ram_we;
	logic [bw-1:0] ram_waddr;
	logic [7:0] ram_wdata;
	logic [7:0] ram_rdata;
	logic [bw-1:0] ram_raddr;
	logic timer_clear;
	logic expired;
	logic last;

	function automatic logic sw_hit(input logic [3:0] a, input logic [3:0] r, input logic s);
		sw_hit = s && (a == r);
	endfunction : sw_hit

	assign last = (index == (bw+1)'(block_bytes - 1));
	assign timer_clear = (state != next_state);
	// fill reads one byte ahead so the registered ram output matches index
	assign ram_raddr = (state == st_fill && !rd_wait && !last) ? index[bw-1:0] + 1'b1 : index[bw-1:0];

	flash_block_ram #(.depth(block_bytes), .aw(bw)) image_ram (
		.ref_clk(ref_clk),
		.we(ram_we),
		.waddr(ram_waddr),
		.wdata(ram_wdata),
		.raddr(ram_raddr),
		.rdata(ram_rdata)
	);

	// long device operations are bounded so a dead device cannot hang the host
	flash_cycle_timer #(.limit(busy_limit)) busy_timer (
		.ref_clk(ref_clk),
		.rst(rst),
		.clear(timer_clear),
		.run(state == st_erase || state == st_wait),
		.expired(expired)
	);

	// =====================================================
	// next state
	always_comb
	begin
		next_state = state;
		case (state)
			st_idle:
				if (sw_hit(sw_addr, reg_ctrl, sw_wr) && sw_wdata[ctrl_start_bit])
					next_state = st_read;
			st_read:
				if (table_rvalid && last)
					next_state = st_erase;
			st_erase:
				if (expired)
					next_state = st_done;
				else if (busy_seen && !dev_busy)
					next_state = st_load;
			st_load:
				next_state = st_fill;
			st_fill:
				if (!rd_wait && last)
					next_state = st_setup;
			st_setup:
				next_state = st_unlock1;
			st_unlock1:
				next_state = st_unlock2;
			st_unlock2:
				next_state = st_go;
			st_go:
				next_state = st_wait;
			st_wait:
				if (expired)
					next_state = st_done;
				else if (busy_seen && !dev_busy && !write_start_status)
					next_state = st_verify;
			st_verify:
				if (table_rvalid && last)
					next_state = st_done;
			st_done:
				next_state = st_idle;
			default:
				next_state = st_idle;
		endcase
		if (sw_hit(sw_addr, reg_ctrl, sw_wr) && sw_wdata[ctrl_abort_bit]
			&& state != st_wait && state != st_go)
			next_state = st_idle;
	end

	always_ff @(posedge ref_clk)
	begin
		if (rst)
			state <= st_idle;
		else
			state <= next_state;
	end

	// =====================================================
	// byte index and ram read latency
	always_ff @(posedge ref_clk)
	begin
		if (rst || state != next_state)
			index <= '0;
		else if ((state == st_read || state == st_verify) && table_rvalid)
			index <= index + 1'b1;
		else if (state == st_fill && !rd_wait && !last)
			index <= index + 1'b1;
	end

	always_ff @(posedge ref_clk)
	begin
		if (rst || state != st_fill)
			rd_wait <= 1'b1;
		else
			rd_wait <= 1'b0;
	end

	always_ff @(posedge ref_clk)
	begin
		if (rst)
			busy_seen <= 1'b0;
		else if (state != next_state)
			busy_seen <= 1'b0;
		else if (dev_busy)
			busy_seen <= 1'b1;
	end

	// =====================================================
	// image buffer writes: read-back with software patch applied
	always_comb
	begin
		ram_we = 1'b0;
		ram_waddr = index[bw-1:0];
		ram_wdata = table_rdata;
		if (state == st_read && table_rvalid)
		begin
			ram_we = 1'b1;
			if (patch_pending && patch_index == index[bw-1:0])
				ram_wdata = patch_data;
		end
		else if (state == st_idle && sw_hit(sw_addr, reg_data, sw_wr))
		begin
			ram_we = 1'b1;
			ram_waddr = sw_wdata[8+bw-1:8];
			ram_wdata = sw_wdata[7:0];
		end
	end

	// =====================================================
	// software registers
	always_ff @(posedge ref_clk)
	begin
		if (rst)
			base <= '0;
		else if (state == st_idle && sw_hit(sw_addr, reg_base, sw_wr))
			base <= {sw_wdata[addr_width-1:bw], {bw{1'b0}}};
	end

	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			patch_pending <= 1'b0;
			patch_data <= 8'h00;
			patch_index <= '0;
		end
		else if (state == st_idle && sw_hit(sw_addr, reg_index, sw_wr))
		begin
			patch_pending <= sw_wdata[31];
			patch_index <= sw_wdata[8+bw-1:8];
			patch_data <= sw_wdata[7:0];
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			error_flag <= 1'b0;
			timeout_flag <= 1'b0;
			mismatch_count <= '0;
		end
		else if (state == st_idle && next_state == st_read)
		begin
			error_flag <= 1'b0;
			timeout_flag <= 1'b0;
			mismatch_count <= '0;
		end
		else
		begin
			if (expired)
				timeout_flag <= 1'b1;
			if (state == st_verify && table_rvalid && table_rdata != ram_rdata)
			begin
				error_flag <= 1'b1;
				mismatch_count <= mismatch_count + 1'b1;
			end
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (rst)
			sw_rdata <= 32'h0000_0000;
		else if (sw_rd)
			case (sw_addr)
				reg_status:
					sw_rdata <= {24'h00_0000, 1'b0, timeout_flag, error_flag,
						(state == st_idle), state};
				reg_base:
					sw_rdata <= 32'(base);
				reg_mismatch:
					sw_rdata <= 32'(mismatch_count);
				default:
					sw_rdata <= 32'h0000_0000;
			endcase
		else
			sw_rdata <= 32'h0000_0000;
	end

	// =====================================================
	// device side outputs
	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			table_addr <= '0;
			table_addr_load <= 1'b0;
			table_write <= 1'b0;
			table_wdata <= 8'h00;
			table_read <= 1'b0;
			erase_start <= 1'b0;
		end
		else
		begin
			table_addr_load <= 1'b0;
			table_write <= 1'b0;
			table_read <= 1'b0;
			erase_start <= 1'b0;
			if (state == st_idle && next_state == st_read)
			begin
				table_addr <= base;
				table_addr_load <= 1'b1;
			end
			if ((state == st_read || state == st_verify) && index == '0 && !busy_seen)
				table_read <= 1'b0;
			if ((state == st_read && next_state == st_read)
				|| (state == st_verify && next_state == st_verify))
				table_read <= !table_read && !table_rvalid ? 1'b1 : 1'b0;
			if (state == st_read && next_state == st_erase)
			begin
				table_addr <= base;
				table_addr_load <= 1'b1;
				erase_start <= 1'b1;
			end
			if (state == st_load)
			begin
				table_addr <= base;
				table_addr_load <= 1'b1;
			end
			if (state == st_fill && !rd_wait)
			begin
				table_write <= 1'b1;
				table_wdata <= ram_rdata;
			end
			if (state == st_setup)
			begin
				table_addr <= base;
				table_addr_load <= 1'b1;
			end
			if (state == st_wait && next_state == st_verify)
			begin
				table_addr <= base;
				table_addr_load <= 1'b1;
			end
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			mem_control_one <= 8'h00;
			mem_control_write <= 1'b0;
			unlock_data <= 8'h00;
			unlock_write <= 1'b0;
		end
		else
		begin
			mem_control_write <= 1'b0;
			unlock_write <= 1'b0;
			case (state)
				st_setup:
				begin
					mem_control_one <= 8'h00;
					mem_control_one[region_lsb +: 2] <= region_program;
					mem_control_one[erase_sel_bit] <= 1'b0;
					mem_control_one[write_en_bit] <= 1'b1;
					mem_control_write <= 1'b1;
				end
				st_unlock1:
				begin
					unlock_data <= unlock_first;
					unlock_write <= 1'b1;
				end
				st_unlock2:
				begin
					unlock_data <= unlock_second;
					unlock_write <= 1'b1;
				end
				st_go:
				begin
					mem_control_one[write_start_bit] <= 1'b1;
					mem_control_write <= 1'b1;
				end
				st_wait:
					mem_control_one[write_start_bit] <= 1'b0;
				default:
					mem_control_one[write_en_bit] <= 1'b0;
			endcase
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (rst)
			irq_disable <= 1'b0;
		else if (state == st_setup)
			irq_disable <= 1'b1;
		else if (state == st_verify || state == st_done || state == st_idle)
			irq_disable <= 1'b0;
	end

	// =====================================================
	// checks
	unlock_order_a: assert property (@(posedge ref_clk) disable iff (rst)
		(unlock_write && unlock_data == unlock_second) |=> mem_control_write
			&& mem_control_one[write_start_bit])
		else $error("write start not right after unlock");
	irq_held_a: assert property (@(posedge ref_clk) disable iff (rst)
		unlock_write |-> irq_disable)
		else $error("unlock with interrupts enabled");
	write_mode_a: assert property (@(posedge ref_clk) disable iff (rst)
		(mem_control_write && mem_control_one[write_start_bit]) |->
			mem_control_one[write_en_bit] && !mem_control_one[erase_sel_bit])
		else $error("write started in erase mode");
	region_sel_a: assert property (@(posedge ref_clk) disable iff (rst)
		(mem_control_write && mem_control_one[write_start_bit]) |->
			mem_control_one[region_lsb +: 2] == region_program)
		else $error("region not program flash");
	addr_reload_a: assert property (@(posedge ref_clk) disable iff (rst)
		(state == st_load) |=> table_addr_load && table_addr == base)
		else $error("table address not reloaded");
	setup_addr_a: assert property (@(posedge ref_clk) disable iff (rst)
		(state == st_setup) |=> table_addr == base)
		else $error("table address outside block");
	wait_release_a: assert property (@(posedge ref_clk) disable iff (rst)
		(state == st_wait && next_state == st_verify) |-> !write_start_status)
		else $error("released while write start set");
	erase_first_a: assert property (@(posedge ref_clk) disable iff (rst)
		(state == st_erase && next_state == st_load) |-> busy_seen && !dev_busy)
		else $error("fill before erase completes");
endmodule : flash_block_write_sequencer
`default_nettype wire

//--- verif/flash_dev_model.sv
// behavioural model of the flash device behind the sequencer
`timescale 1ns/10ps
`default_nettype none
module flash_dev_model
	import flash_seq_pkg::*;
#(
	parameter int nb = 16,
	parameter int erase_len = 80,
	parameter int write_len = 40
)
(
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic [1:0] mode,
	input wire logic [21:0] table_addr,
	input wire logic table_addr_load,
	input wire logic table_write,
	input wire logic [7:0] table_wdata,
	input wire logic table_read,
	output logic [7:0] table_rdata,
	output logic table_rvalid,
	input wire logic [7:0] mem_control_one,
	input wire logic mem_control_write,
	input wire logic [7:0] unlock_data,
	input wire logic unlock_write,
	input wire logic erase_start,
	input wire logic irq_disable,
	output logic dev_busy,
	output logic write_start_status,
	output logic [7:0] faults
);
	// ==========================================================
	// state
	localparam logic [7:0] msk = 8'(nb - 1);
	logic [7:0] mem [0:255];
	logic [7:0] lat [0:nb-1];
	logic [7:0] tp, cur, obase, lbase;
	logic [1:0] stage;
	logic is_write, erased;
	int cnt;
	assign cur = table_addr_load ? table_addr[7:0] : tp;
	// ==========================================================
	// device behaviour; mode 1 stretches the erase, mode 2 loses byte 3
	always_ff @(posedge ref_clk)
	begin
		table_rvalid <= 1'b0;
		// released data line must not keep the last byte
		table_rdata <= ~table_rdata;
		tp <= cur;
		if (rst)
		begin
			dev_busy <= 1'b0;
			write_start_status <= 1'b0;
			stage <= 2'h0;
			faults <= 8'h0;
			table_rdata <= 8'h0;
			erased <= 1'b0;
			is_write <= 1'b0;
			cnt <= 0;
			// array filled here so only this process drives it
			for (int i = 0; i < 256; i++)
				mem[i] <= 8'(i * 3 + 1);
		end
		else if (dev_busy)
		begin
			cnt <= cnt - 1;
			if (is_write && !irq_disable)
				faults <= faults + 8'h1;
			if (cnt == 2 && is_write)
			begin
				for (int j = 0; j < nb; j++)
					if (!(mode == 2'h2 && j == 3))
						mem[obase + 8'(j)] <= lat[j];
				write_start_status <= 1'b0;
				erased <= 1'b0;
			end
			if (cnt == 1)
			begin
				dev_busy <= 1'b0;
				if (!is_write)
					for (int j = 0; j < nb; j++)
						mem[obase + 8'(j)] <= 8'hff;
				erased <= erased | !is_write;
			end
		end
		else
		begin
			if (table_read)
			begin
				table_rdata <= mem[cur];
				table_rvalid <= 1'b1;
				tp <= cur + 8'h1;
			end
			if (table_write)
			begin
				lat[cur & msk] <= table_wdata;
				lbase <= cur & ~msk;
				tp <= cur + 8'h1;
				if (!erased)
					faults <= faults + 8'h1;
			end
			if (unlock_write)
				stage <= (unlock_data == unlock_first) ? 2'h1 :
					(stage == 2'h1 && unlock_data == unlock_second) ? 2'h2 : 2'h0;
			if (erase_start)
			begin
				obase <= cur & ~msk;
				dev_busy <= 1'b1;
				is_write <= 1'b0;
				cnt <= (mode == 2'h1) ? erase_len * 8 : erase_len;
			end
			if (mem_control_write)
			begin
				stage <= 2'h0;
				if (mem_control_one[write_start_bit] && (stage != 2'h2 || !irq_disable ||
					mem_control_one[7:6] != region_program || mem_control_one[erase_sel_bit] ||
					!mem_control_one[write_en_bit] || (cur & ~msk) != lbase || !erased))
					faults <= faults + 8'h1;
				else if (mem_control_one[write_start_bit])
				begin
					obase <= lbase;
					dev_busy <= 1'b1;
					write_start_status <= 1'b1;
					is_write <= 1'b1;
					cnt <= write_len;
				end
			end
		end
	end
endmodule : flash_dev_model
`default_nettype wire

//--- verif/tb.sv
// self-checking testbench for the flash block write sequencer
`timescale 1ns/10ps
`default_nettype none
module tb;
	import flash_seq_pkg::*;
	localparam int nb = 16;
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic [3:0] sw_addr = 4'h0;
	logic [31:0] sw_wdata = 32'h0;
	logic sw_wr = 1'b0;
	logic sw_rd = 1'b0;
	logic [1:0] mode = 2'h0;
	logic [31:0] sw_rdata, rd;
	logic [21:0] table_addr;
	logic table_addr_load, table_write, table_read, table_rvalid, mem_control_write;
	logic unlock_write, erase_start, irq_disable, dev_busy, write_start_status;
	logic [7:0] table_wdata, table_rdata, mem_control_one, unlock_data, faults;
	int errors = 0;
	int comparisons = 0;
	always #10 ref_clk = ~ref_clk;
	// ==========================================================
	// design and device
	flash_block_write_sequencer #(.block_bytes(nb), .addr_width(22), .busy_limit(200)) u_dut (
		.ref_clk(ref_clk), .rst(rst), .sw_addr(sw_addr), .sw_wdata(sw_wdata),
		.sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata), .table_addr(table_addr),
		.table_addr_load(table_addr_load), .table_write(table_write),
		.table_wdata(table_wdata), .table_read(table_read), .table_rdata(table_rdata),
		.table_rvalid(table_rvalid), .mem_control_one(mem_control_one),
		.mem_control_write(mem_control_write), .unlock_data(unlock_data),
		.unlock_write(unlock_write), .erase_start(erase_start), .irq_disable(irq_disable),
		.dev_busy(dev_busy), .write_start_status(write_start_status));
	flash_dev_model #(.nb(nb)) u_dev (
		.ref_clk(ref_clk), .rst(rst), .mode(mode), .table_addr(table_addr),
		.table_addr_load(table_addr_load), .table_write(table_write),
		.table_wdata(table_wdata), .table_read(table_read), .table_rdata(table_rdata),
		.table_rvalid(table_rvalid), .mem_control_one(mem_control_one),
		.mem_control_write(mem_control_write), .unlock_data(unlock_data),
		.unlock_write(unlock_write), .erase_start(erase_start), .irq_disable(irq_disable),
		.dev_busy(dev_busy), .write_start_status(write_start_status), .faults(faults));
	// ==========================================================
	// shared tasks
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (got !== exp)
		begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic sw_write(input logic [3:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		sw_wr <= 1'b1;
		sw_addr <= a;
		sw_wdata <= d;
		@(posedge ref_clk);
		sw_wr <= 1'b0;
	endtask : sw_write
	task automatic sw_read(input logic [3:0] a);
		@(posedge ref_clk);
		sw_rd <= 1'b1;
		sw_addr <= a;
		@(posedge ref_clk);
		sw_rd <= 1'b0;
		#1 rd = sw_rdata;
	endtask : sw_read
	function automatic logic [31:0] orig(input int i);
		return {24'h0, 8'(i * 3 + 1)};
	endfunction : orig
	// poll bounded: a hung sequencer must not stall the run
	task automatic run_block(input logic [21:0] base, input logic [31:0] patch);
		int n;
		sw_write(reg_base, {10'h0, base});
		sw_write(reg_index, patch);
		sw_write(reg_ctrl, 32'h1 << ctrl_start_bit);
		n = 0;
		rd = 32'h0;
		while (rd[4] !== 1'b1 && n < 3000)
		begin
			sw_read(reg_status);
			n++;
		end
		chk("idle", 32'h10, rd & 32'h1f);
	endtask : run_block
	// ==========================================================
	// scenarios
	task automatic t_reset;
		sw_read(reg_status);
		chk("status", 32'h10, rd & 32'h7f);
		sw_read(4'hf);
		chk("unmapped", 32'h0, rd);
		sw_read(reg_mismatch);
		chk("mismatch", 32'h0, rd);
		$display("t_reset done");
	endtask : t_reset
	task automatic t_update;
		run_block(22'h20, {1'b1, 17'h0, 6'(nb - 1), 8'hc3});
		sw_read(reg_status);
		chk("status", 32'h10, rd & 32'h7f);
		sw_read(reg_mismatch);
		chk("mismatch", 32'h0, rd);
		for (int j = 0; j < nb - 1; j++)
			chk("mem", orig(32 + j), {24'h0, u_dev.mem[32 + j]});
		chk("patched", 32'hc3, {24'h0, u_dev.mem[32 + nb - 1]});
		chk("below", orig(31), {24'h0, u_dev.mem[31]});
		chk("above", orig(48), {24'h0, u_dev.mem[48]});
		chk("faults", 32'h0, {24'h0, faults});
		chk("irq_disable", 32'h0, {31'h0, irq_disable});
		$display("t_update done");
	endtask : t_update
	task automatic t_abort;
		sw_write(reg_base, 32'h0000_0060);
		sw_write(reg_ctrl, 32'h1 << ctrl_start_bit);
		sw_write(reg_ctrl, 32'h1 << ctrl_abort_bit);
		sw_read(reg_status);
		chk("abort", 32'h10, rd & 32'h1f);
		repeat (100) @(posedge ref_clk);
		chk("untouched", orig(96), {24'h0, u_dev.mem[8'h60]});
		chk("no erase", 32'h0, {31'h0, dev_busy});
		chk("faults", 32'h0, {24'h0, faults});
		$display("t_abort done");
	endtask : t_abort
	task automatic t_timeout;
		int n;
		mode <= 2'h1;
		run_block(22'h40, 32'h0);
		sw_read(reg_status);
		chk("timeout", 32'h40, rd & 32'h40);
		n = 0;
		while (dev_busy !== 1'b0 && n < 2000)
		begin
			@(posedge ref_clk);
			n++;
		end
		mode <= 2'h0;
		chk("dev_busy", 32'h0, {31'h0, dev_busy});
		$display("t_timeout done");
	endtask : t_timeout
	task automatic t_drop;
		mode <= 2'h2;
		run_block(22'h50, {1'b1, 17'h0, 6'h0, 8'h3c});
		mode <= 2'h0;
		sw_read(reg_mismatch);
		chk("mismatch", 32'h1, rd);
		sw_read(reg_status);
		chk("error", 32'h20, rd & 32'h20);
		chk("patched", 32'h3c, {24'h0, u_dev.mem[8'h50]});
		chk("faults", 32'h0, {24'h0, faults});
		$display("t_drop done");
	endtask : t_drop
	// ==========================================================
	// run control
	task automatic tally_and_finish;
		$display("comparisons %0d errors %0d", comparisons, errors);
		if (errors == 0 && comparisons > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : tally_and_finish
	initial
	begin
		repeat (3) @(posedge ref_clk);
		rst <= 1'b0;
		t_reset;
		t_update;
		t_abort;
		t_timeout;
		t_drop;
		tally_and_finish;
	end
	// all scenarios need well under this many cycles
	initial
	begin
		repeat (40000) @(posedge ref_clk);
		errors++;
		tally_and_finish;
	end
endmodule : tb
`default_nettype wire
